/* hw/bcd_pkg.sv */
// Shared encodings, cycle figures and operand decoding for the decoder
package bcd_pkg;

	typedef enum logic [3:0] {
		FORM_NONE,
		FORM_SOFTWARE_BREAK,
		FORM_BIT_SET_SHORT,
		FORM_BIT_INVERT_SHORT,
		FORM_BIT_TEST_SHORT,
		FORM_BIT_GENERAL,
		FORM_COMPARE_IMM_GEN,
		FORM_COMPARE_QUICK,
		FORM_COMPARE_IMM_SHORT,
		FORM_COMPARE_REG_MEM,
		FORM_COMPARE_ACCUM,
		FORM_ILLEGAL
	} bcd_form_e;

	typedef enum logic [3:0] {
		BOP_NONE,
		BOP_BIT_INVERT,
		BOP_BIT_SET,
		BOP_BIT_TEST,
		BOP_BIT_INVERTED_TEST,
		BOP_BIT_INVERTED_XOR,
		BOP_BIT_OR_CARRY,
		BOP_BIT_TEST_AND_CLEAR,
		BOP_BIT_TEST_AND_SET,
		BOP_BIT_XOR_CARRY
	} bcd_bitop_e;

	typedef enum logic [2:0] {
		CLS_DATA_REG,
		CLS_ADDR_REG,
		CLS_INDIRECT,
		CLS_DSP8_AREG,
		CLS_DSP8_BASE,
		CLS_DSP16_AREG,
		CLS_DSP16_BASE,
		CLS_ABS16
	} bcd_class_e;

	typedef enum {
		ST_OPCODE,
		ST_SECOND,
		ST_EXT
	} bcd_state_e;

	// First opcode byte patterns
	localparam logic [7:0] OPC_SOFTWARE_BREAK  = 8'h00;
	localparam logic [7:0] OPC_BIT_GENERAL     = 8'h7e;
	localparam logic [4:0] OPC5_BIT_SET_SHORT  = 5'h09;
	localparam logic [4:0] OPC5_BIT_INV_SHORT  = 5'h0a;
	localparam logic [4:0] OPC5_BIT_TEST_SHORT = 5'h0b;
	localparam logic [4:0] OPC5_CMP_IMM_SHORT  = 5'h1d;
	localparam logic [4:0] OPC5_CMP_ACCUM      = 5'h07;
	localparam logic [6:0] OPC7_CMP_IMM_GEN    = 7'h3b;
	localparam logic [6:0] OPC7_CMP_QUICK      = 7'h68;
	localparam logic [6:0] OPC7_CMP_REG_MEM    = 7'h60;

	// Upper nibble of the second byte
	localparam logic [3:0] SUB_CMP_IMM_GEN  = 4'h8;
	localparam logic [3:0] SUB_BIT_INVERT   = 4'ha;
	localparam logic [3:0] SUB_BIT_SET      = 4'h9;
	localparam logic [3:0] SUB_BIT_TEST     = 4'hb;
	localparam logic [3:0] SUB_BIT_INV_TEST = 4'h3;
	localparam logic [3:0] SUB_BIT_INV_XOR  = 4'hd;
	localparam logic [3:0] SUB_BIT_OR       = 4'h6;
	localparam logic [3:0] SUB_BIT_TST_CLR  = 4'h0;
	localparam logic [3:0] SUB_BIT_TST_SET  = 4'h1;
	localparam logic [3:0] SUB_BIT_XOR      = 4'hc;

	// Short destination and source codes
	localparam logic [2:0] SDST_ACCUM_HIGH  = 3'h3;
	localparam logic [2:0] SDST_ACCUM_LOW   = 3'h4;
	localparam logic [2:0] SDST_STATIC_BASE = 3'h5;
	localparam logic [2:0] SDST_FRAME_BASE  = 3'h6;
	localparam logic [2:0] SDST_ABS16       = 3'h7;
	localparam logic [1:0] SSRC_OTHER_ACCUM = 2'h0;
	localparam logic [1:0] SSRC_ABS16       = 2'h3;

	// Lengths in bytes
	localparam logic [2:0] LEN_ONE_BYTE  = 3'd1;
	localparam logic [2:0] LEN_TWO_BYTES = 3'd2;
	localparam logic [2:0] EXT_ONE       = 3'd1;
	localparam logic [2:0] EXT_TWO       = 3'd2;

	// Cycle counts
	localparam logic [4:0] CYC_BREAK         = 5'd27;
	localparam logic [4:0] CYC_BREAK_TABLE   = 5'd2;
	localparam logic [4:0] CYC_BIT_SHORT     = 5'd3;
	localparam logic [4:0] CYC_BITA_REG      = 5'd2;
	localparam logic [4:0] CYC_BITA_IND      = 5'd6;
	localparam logic [4:0] CYC_BITA_BASE     = 5'd3;
	localparam logic [4:0] CYC_BITB_REG      = 5'd3;
	localparam logic [4:0] CYC_BITB_IND      = 5'd7;
	localparam logic [4:0] CYC_BITB_BASE     = 5'd4;
	localparam logic [4:0] CYC_CMPG_REG      = 5'd2;
	localparam logic [4:0] CYC_CMPG_MEM      = 5'd4;
	localparam logic [4:0] CYC_CMPQ_REG      = 5'd1;
	localparam logic [4:0] CYC_CMPQ_MEM      = 5'd3;
	localparam logic [4:0] CYC_CMPS_REG      = 5'd1;
	localparam logic [4:0] CYC_CMPS_MEM      = 5'd3;
	localparam logic [4:0] CYC_CMPRM_NONE    = 5'd2;
	localparam logic [4:0] CYC_CMPRM_ONE     = 5'd3;
	localparam logic [4:0] CYC_CMPRM_BOTH    = 5'd4;
	localparam logic [4:0] CYC_CMPA_REG      = 5'd2;
	localparam logic [4:0] CYC_CMPA_MEM      = 5'd3;

	// Addressing class of a 4-bit operand code
	function automatic bcd_class_e opnd_class(input logic [3:0] code);
		bcd_class_e c;
		c = CLS_DATA_REG;
		case (code[3:1])
			3'h0, 3'h1: c = CLS_DATA_REG;
			3'h2: c = CLS_ADDR_REG;
			3'h3: c = CLS_INDIRECT;
			3'h4: c = CLS_DSP8_AREG;
			3'h5: c = CLS_DSP8_BASE;
			3'h6: c = CLS_DSP16_AREG;
			default: c = code[0] ? CLS_ABS16 : CLS_DSP16_BASE;
		endcase
		return c;
	endfunction

	// Displacement bytes of a general data operand
	function automatic logic [2:0] gen_ext_len(input logic [3:0] code);
		logic [2:0] n;
		n = 3'd0;
		if (code[3])
			n = code[2] ? EXT_TWO : EXT_ONE;
		return n;
	endfunction

	// Indirect and memory operands cost extra cycles
	function automatic logic is_mem(input logic [3:0] code);
		return code[3] | (code[2] & code[1]);
	endfunction

	// Extension bytes of a 2-bit short operand code
	function automatic logic [2:0] short_ext_len(input logic [1:0] sel);
		logic [2:0] n;
		n = 3'd0;
		case (sel)
			2'h0: n = 3'd0;
			2'h3: n = EXT_TWO;
			default: n = EXT_ONE;
		endcase
		return n;
	endfunction

endpackage

/* hw/bcd_dec_if.sv */
// First-byte classification signals between the decoder and its classifier
`timescale 1ns/1ns
interface bcd_dec_if;
	logic [7:0]         opcode;
	bcd_pkg::bcd_form_e form;
	logic               needs_second;

	modport classify (
		input  opcode,
		output form,
		output needs_second
	);
	modport user (
		output opcode,
		input  form,
		input  needs_second
	);
endinterface

/* hw/bcd_first_byte.sv */
// Combinational classification of the first opcode byte
`timescale 1ns/1ns
module bcd_first_byte (
	bcd_dec_if.classify dec
);

	always_comb begin
		dec.form = bcd_pkg::FORM_ILLEGAL;
		dec.needs_second = 1'b0;
		if (dec.opcode == bcd_pkg::OPC_SOFTWARE_BREAK) begin
			dec.form = bcd_pkg::FORM_SOFTWARE_BREAK;
		end else if (dec.opcode == bcd_pkg::OPC_BIT_GENERAL) begin
			dec.form = bcd_pkg::FORM_BIT_GENERAL;
			dec.needs_second = 1'b1;
		end else begin
			case (dec.opcode[7:3])
				bcd_pkg::OPC5_BIT_SET_SHORT:
					dec.form = bcd_pkg::FORM_BIT_SET_SHORT;
				bcd_pkg::OPC5_BIT_INV_SHORT:
					dec.form = bcd_pkg::FORM_BIT_INVERT_SHORT;
				bcd_pkg::OPC5_BIT_TEST_SHORT:
					dec.form = bcd_pkg::FORM_BIT_TEST_SHORT;
				bcd_pkg::OPC5_CMP_IMM_SHORT:
					dec.form = bcd_pkg::FORM_COMPARE_IMM_SHORT;
				bcd_pkg::OPC5_CMP_ACCUM:
					dec.form = bcd_pkg::FORM_COMPARE_ACCUM;
				default: begin
					dec.needs_second = 1'b1;
					case (dec.opcode[7:1])
						bcd_pkg::OPC7_CMP_IMM_GEN:
							dec.form = bcd_pkg::FORM_COMPARE_IMM_GEN;
						bcd_pkg::OPC7_CMP_QUICK:
							dec.form = bcd_pkg::FORM_COMPARE_QUICK;
						bcd_pkg::OPC7_CMP_REG_MEM:
							dec.form = bcd_pkg::FORM_COMPARE_REG_MEM;
						default: begin
							dec.form = bcd_pkg::FORM_ILLEGAL;
							dec.needs_second = 1'b0;
						end
					endcase
				end
			endcase
		end
	end

endmodule

/* hw/bcd_decoder.sv */
// Bit-manipulation and compare instruction decoder with length and cycles
`timescale 1ns/1ns
module bcd_decoder (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 byte_valid,
	input  wire logic [7:0]           byte_data,
	input  wire logic                 vector_from_table,
	output logic                      byte_ready_r,
	output logic                      done_r,
	output logic                      illegal_r,
	output bcd_pkg::bcd_form_e        form_r,
	output bcd_pkg::bcd_bitop_e       bit_op_r,
	output bcd_pkg::bcd_class_e       src_class_r,
	output bcd_pkg::bcd_class_e       dst_class_r,
	output logic [3:0]                src_code_r,
	output logic [3:0]                dst_code_r,
	output logic [2:0]                bit_num_r,
	output logic                      size_word_r,
	output logic signed [3:0]         quick_immediate_r,
	output logic [31:0]               ext_data_r,
	output logic [2:0]                src_ext_len_r,
	output logic [2:0]                length_r,
	output logic [4:0]                cycles_r
);

	bcd_dec_if              dec ();
	bcd_pkg::bcd_state_e    state_r;
	bcd_pkg::bcd_form_e     held_form_r;
	logic [2:0]             ext_need_r;
	logic [2:0]             ext_cnt_r;
	logic                   take;
	logic                   finish;
	logic                   go_ext;
	logic                   bad;
	bcd_pkg::bcd_form_e     form_nxt;
	bcd_pkg::bcd_bitop_e    bit_op_nxt;
	logic [3:0]             src_nxt;
	logic [3:0]             dst_nxt;
	logic [2:0]             bit_nxt;
	logic                   size_nxt;
	logic [3:0]             qimm_nxt;
	logic [2:0]             ext_nxt;
	logic [2:0]             src_ext_nxt;
	logic [2:0]             len_nxt;
	logic [4:0]             cyc_nxt;
	logic                   load;

	assign dec.opcode = byte_data;

	bcd_first_byte u_first (
		.dec (dec.classify)
	);

	assign take = byte_valid & byte_ready_r;

	// Decode of the byte currently offered, per state
	always_comb begin
		form_nxt = held_form_r;
		bit_op_nxt = bit_op_r;
		src_nxt = src_code_r;
		dst_nxt = dst_code_r;
		bit_nxt = bit_num_r;
		size_nxt = size_word_r;
		qimm_nxt = quick_immediate_r;
		ext_nxt = 3'd0;
		src_ext_nxt = 3'd0;
		len_nxt = bcd_pkg::LEN_ONE_BYTE;
		cyc_nxt = 5'd0;
		load = 1'b0;
		bad = 1'b0;
		if (state_r == bcd_pkg::ST_OPCODE) begin
			load = 1'b1;
			form_nxt = dec.form;
			bit_op_nxt = bcd_pkg::BOP_NONE;
			src_nxt = 4'h0;
			dst_nxt = 4'h0;
			bit_nxt = 3'h0;
			size_nxt = byte_data[0];
			qimm_nxt = 4'h0;
			case (dec.form)
				bcd_pkg::FORM_SOFTWARE_BREAK: begin
					cyc_nxt = vector_from_table ?
						bcd_pkg::CYC_BREAK + bcd_pkg::CYC_BREAK_TABLE :
						bcd_pkg::CYC_BREAK;
				end
				bcd_pkg::FORM_BIT_SET_SHORT,
				bcd_pkg::FORM_BIT_INVERT_SHORT,
				bcd_pkg::FORM_BIT_TEST_SHORT: begin
					bit_nxt = byte_data[2:0];
					bit_op_nxt = (dec.form == bcd_pkg::FORM_BIT_SET_SHORT) ?
						bcd_pkg::BOP_BIT_SET :
						(dec.form == bcd_pkg::FORM_BIT_TEST_SHORT) ?
						bcd_pkg::BOP_BIT_TEST : bcd_pkg::BOP_BIT_INVERT;
					ext_nxt = bcd_pkg::EXT_ONE;
					cyc_nxt = bcd_pkg::CYC_BIT_SHORT;
				end
				bcd_pkg::FORM_COMPARE_IMM_SHORT: begin
					dst_nxt = {1'b0, byte_data[2:0]};
					size_nxt = 1'b0;
					bad = byte_data[2:0] < bcd_pkg::SDST_ACCUM_HIGH;
					src_ext_nxt = bcd_pkg::EXT_ONE;
					case (byte_data[2:0])
						bcd_pkg::SDST_STATIC_BASE,
						bcd_pkg::SDST_FRAME_BASE: begin
							ext_nxt = 3'd2;
							cyc_nxt = bcd_pkg::CYC_CMPS_MEM;
						end
						bcd_pkg::SDST_ABS16: begin
							ext_nxt = 3'd3;
							cyc_nxt = bcd_pkg::CYC_CMPS_MEM;
						end
						default: begin
							ext_nxt = bcd_pkg::EXT_ONE;
							cyc_nxt = bcd_pkg::CYC_CMPS_REG;
						end
					endcase
				end
				bcd_pkg::FORM_COMPARE_ACCUM: begin
					src_nxt = {2'b00, byte_data[1:0]};
					dst_nxt = {3'b000, byte_data[2]};
					size_nxt = 1'b0;
					ext_nxt = bcd_pkg::short_ext_len(byte_data[1:0]);
					src_ext_nxt = ext_nxt;
					cyc_nxt = (byte_data[1:0] == bcd_pkg::SSRC_OTHER_ACCUM) ?
						bcd_pkg::CYC_CMPA_REG : bcd_pkg::CYC_CMPA_MEM;
				end
				bcd_pkg::FORM_ILLEGAL: bad = 1'b1;
				default: bad = 1'b0;
			endcase
			len_nxt = bcd_pkg::LEN_ONE_BYTE + ext_nxt;
		end else if (state_r == bcd_pkg::ST_SECOND) begin
			load = 1'b1;
			dst_nxt = byte_data[3:0];
			case (held_form_r)
				bcd_pkg::FORM_BIT_GENERAL: begin
					case (bcd_pkg::opnd_class(byte_data[3:0]))
						bcd_pkg::CLS_DATA_REG,
						bcd_pkg::CLS_ADDR_REG: ext_nxt = bcd_pkg::EXT_ONE;
						bcd_pkg::CLS_INDIRECT: ext_nxt = 3'd0;
						default: ext_nxt = bcd_pkg::gen_ext_len(byte_data[3:0]);
					endcase
					case (byte_data[7:4])
						bcd_pkg::SUB_BIT_INVERT: bit_op_nxt = bcd_pkg::BOP_BIT_INVERT;
						bcd_pkg::SUB_BIT_SET: bit_op_nxt = bcd_pkg::BOP_BIT_SET;
						bcd_pkg::SUB_BIT_TEST: bit_op_nxt = bcd_pkg::BOP_BIT_TEST;
						bcd_pkg::SUB_BIT_INV_TEST:
							bit_op_nxt = bcd_pkg::BOP_BIT_INVERTED_TEST;
						bcd_pkg::SUB_BIT_INV_XOR:
							bit_op_nxt = bcd_pkg::BOP_BIT_INVERTED_XOR;
						bcd_pkg::SUB_BIT_OR: bit_op_nxt = bcd_pkg::BOP_BIT_OR_CARRY;
						bcd_pkg::SUB_BIT_TST_CLR:
							bit_op_nxt = bcd_pkg::BOP_BIT_TEST_AND_CLEAR;
						bcd_pkg::SUB_BIT_TST_SET:
							bit_op_nxt = bcd_pkg::BOP_BIT_TEST_AND_SET;
						bcd_pkg::SUB_BIT_XOR: bit_op_nxt = bcd_pkg::BOP_BIT_XOR_CARRY;
						default: begin
							bit_op_nxt = bcd_pkg::BOP_NONE;
							bad = 1'b1;
						end
					endcase
					// Invert, set and test skip the carry merge
					if (bit_op_nxt == bcd_pkg::BOP_BIT_INVERT ||
						bit_op_nxt == bcd_pkg::BOP_BIT_SET ||
						bit_op_nxt == bcd_pkg::BOP_BIT_TEST) begin
						case (bcd_pkg::opnd_class(byte_data[3:0]))
							bcd_pkg::CLS_DATA_REG, bcd_pkg::CLS_ADDR_REG:
								cyc_nxt = bcd_pkg::CYC_BITA_REG;
							bcd_pkg::CLS_INDIRECT, bcd_pkg::CLS_DSP8_AREG,
							bcd_pkg::CLS_DSP16_AREG:
								cyc_nxt = bcd_pkg::CYC_BITA_IND;
							default: cyc_nxt = bcd_pkg::CYC_BITA_BASE;
						endcase
					end else begin
						case (bcd_pkg::opnd_class(byte_data[3:0]))
							bcd_pkg::CLS_DATA_REG, bcd_pkg::CLS_ADDR_REG:
								cyc_nxt = bcd_pkg::CYC_BITB_REG;
							bcd_pkg::CLS_INDIRECT, bcd_pkg::CLS_DSP8_AREG,
							bcd_pkg::CLS_DSP16_AREG:
								cyc_nxt = bcd_pkg::CYC_BITB_IND;
							default: cyc_nxt = bcd_pkg::CYC_BITB_BASE;
						endcase
					end
				end
				bcd_pkg::FORM_COMPARE_IMM_GEN: begin
					bad = byte_data[7:4] != bcd_pkg::SUB_CMP_IMM_GEN;
					src_ext_nxt = size_word_r ? bcd_pkg::EXT_TWO :
						bcd_pkg::EXT_ONE;
					ext_nxt = src_ext_nxt + bcd_pkg::gen_ext_len(byte_data[3:0]);
					cyc_nxt = bcd_pkg::is_mem(byte_data[3:0]) ?
						bcd_pkg::CYC_CMPG_MEM : bcd_pkg::CYC_CMPG_REG;
				end
				bcd_pkg::FORM_COMPARE_QUICK: begin
					qimm_nxt = byte_data[7:4];
					ext_nxt = bcd_pkg::gen_ext_len(byte_data[3:0]);
					cyc_nxt = bcd_pkg::is_mem(byte_data[3:0]) ?
						bcd_pkg::CYC_CMPQ_MEM : bcd_pkg::CYC_CMPQ_REG;
				end
				bcd_pkg::FORM_COMPARE_REG_MEM: begin
					src_nxt = byte_data[7:4];
					src_ext_nxt = bcd_pkg::gen_ext_len(byte_data[7:4]);
					ext_nxt = src_ext_nxt + bcd_pkg::gen_ext_len(byte_data[3:0]);
					case ({bcd_pkg::is_mem(byte_data[7:4]),
						bcd_pkg::is_mem(byte_data[3:0])})
						2'b00: cyc_nxt = bcd_pkg::CYC_CMPRM_NONE;
						2'b11: cyc_nxt = bcd_pkg::CYC_CMPRM_BOTH;
						default: cyc_nxt = bcd_pkg::CYC_CMPRM_ONE;
					endcase
				end
				default: bad = 1'b1;
			endcase
			if (bad)
				form_nxt = bcd_pkg::FORM_ILLEGAL;
			len_nxt = bcd_pkg::LEN_TWO_BYTES + ext_nxt;
		end
	end

	assign go_ext = load & ~bad & (ext_nxt != 3'd0) &
		~(state_r == bcd_pkg::ST_OPCODE & dec.needs_second);
	assign finish = take & ~bad & (
		(load & (ext_nxt == 3'd0) &
			~(state_r == bcd_pkg::ST_OPCODE & dec.needs_second)) |
		(state_r == bcd_pkg::ST_EXT & ext_cnt_r + 3'd1 == ext_need_r));

	// Sequencing over opcode, second byte and extension bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= bcd_pkg::ST_OPCODE;
			ext_cnt_r <= 3'd0;
			ext_need_r <= 3'd0;
		end else if (take) begin
			if (bad || finish) begin
				state_r <= bcd_pkg::ST_OPCODE;
			end else if (state_r == bcd_pkg::ST_OPCODE && dec.needs_second) begin
				state_r <= bcd_pkg::ST_SECOND;
			end else if (go_ext) begin
				state_r <= bcd_pkg::ST_EXT;
				ext_need_r <= ext_nxt;
				ext_cnt_r <= 3'd0;
			end else if (state_r == bcd_pkg::ST_EXT) begin
				ext_cnt_r <= ext_cnt_r + 3'd1;
			end
		end
	end

	// Decoded fields, captured from opcode bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_form_r <= bcd_pkg::FORM_NONE;
			form_r <= bcd_pkg::FORM_NONE;
			bit_op_r <= bcd_pkg::BOP_NONE;
			src_code_r <= 4'h0;
			dst_code_r <= 4'h0;
			src_class_r <= bcd_pkg::CLS_DATA_REG;
			dst_class_r <= bcd_pkg::CLS_DATA_REG;
			bit_num_r <= 3'h0;
			size_word_r <= 1'b0;
			quick_immediate_r <= 4'sh0;
			src_ext_len_r <= 3'd0;
			length_r <= 3'd0;
			cycles_r <= 5'd0;
		end else if (take && load) begin
			held_form_r <= form_nxt;
			form_r <= form_nxt;
			bit_op_r <= bit_op_nxt;
			src_code_r <= src_nxt;
			dst_code_r <= dst_nxt;
			src_class_r <= bcd_pkg::opnd_class(src_nxt);
			dst_class_r <= bcd_pkg::opnd_class(dst_nxt);
			bit_num_r <= bit_nxt;
			size_word_r <= size_nxt;
			quick_immediate_r <= qimm_nxt;
			src_ext_len_r <= src_ext_nxt;
			length_r <= len_nxt;
			cycles_r <= cyc_nxt;
		end
	end

	// Extension bytes in fetch order, first byte in the low lane
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_data_r <= 32'h0000_0000;
		end else if (take && state_r == bcd_pkg::ST_OPCODE) begin
			ext_data_r <= 32'h0000_0000;
		end else if (take && state_r == bcd_pkg::ST_EXT) begin
			ext_data_r[{ext_cnt_r[1:0], 3'b000} +: 8] <= byte_data;
		end
	end

	// Completion pulses and fetch acceptance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			illegal_r <= 1'b0;
			byte_ready_r <= 1'b0;
		end else begin
			done_r <= finish;
			illegal_r <= take & bad;
			byte_ready_r <= 1'b1;
		end
	end

endmodule

/* testbench/bcd_decoder_properties.sv */
// Concurrent checks on the decoder's reported forms, lengths and cycles
`timescale 1ns/1ns
module bcd_decoder_properties (
	input logic                clk,
	input logic                rst,
	input logic                vector_from_table,
	input logic                byte_ready_r,
	input logic                done_r,
	input bcd_pkg::bcd_form_e  form_r,
	input bcd_pkg::bcd_bitop_e bit_op_r,
	input logic [3:0]          src_code_r,
	input logic [3:0]          dst_code_r,
	input logic                size_word_r,
	input logic [2:0]          src_ext_len_r,
	input logic [2:0]          length_r,
	input logic [4:0]          cycles_r
);
	logic bit_a;
	logic base_dst;
	logic [2:0] sdst;
	logic [1:0] ssrc;
	assign bit_a = bit_op_r inside {bcd_pkg::BOP_BIT_INVERT,
		bcd_pkg::BOP_BIT_SET, bcd_pkg::BOP_BIT_TEST};
	// Codes 1010, 1011, 1110 and 1111 are the base-relative ones
	assign base_dst = dst_code_r[3] && dst_code_r[1];
	assign sdst = dst_code_r[2:0];
	assign ssrc = src_code_r[1:0];
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	a_fetch_never_refused: assert property (
		$past(rst) == 1'b0 |-> byte_ready_r)
		else $error("byte refused outside reset");
	a_break_fixed_cycles: assert property (
		done_r && form_r == bcd_pkg::FORM_SOFTWARE_BREAK &&
		!$past(vector_from_table) |-> length_r == 3'h1 && cycles_r == 5'h1b)
		else $error("fixed break length or cycles wrong");
	a_break_table_cycles: assert property (
		done_r && form_r == bcd_pkg::FORM_SOFTWARE_BREAK &&
		$past(vector_from_table) |-> cycles_r == 5'h1d)
		else $error("table break cycles wrong");
	a_short_set_cost: assert property (
		done_r && form_r == bcd_pkg::FORM_BIT_SET_SHORT
		|-> length_r == 3'h2 && cycles_r == 5'h3)
		else $error("short bit set cost wrong");
	a_bit_length_code: assert property (
		done_r && form_r == bcd_pkg::FORM_BIT_GENERAL |-> length_r ==
		(dst_code_r < 4'h6 ? 3'h3 : !dst_code_r[3] ? 3'h2 :
		dst_code_r[2] ? 3'h4 : 3'h3))
		else $error("bit operand length wrong");
	a_bit_group_a: assert property (
		done_r && form_r == bcd_pkg::FORM_BIT_GENERAL && bit_a |-> cycles_r ==
		(dst_code_r < 4'h6 ? 5'h2 : base_dst ? 5'h3 : 5'h6))
		else $error("invert/set/test cycles wrong");
	a_bit_group_b: assert property (
		done_r && form_r == bcd_pkg::FORM_BIT_GENERAL && !bit_a |-> cycles_r ==
		(dst_code_r < 4'h6 ? 5'h3 : base_dst ? 5'h4 : 5'h7))
		else $error("other bit op cycles wrong");
	a_cmp_gen_cost: assert property (
		done_r && form_r == bcd_pkg::FORM_COMPARE_IMM_GEN
		|-> cycles_r == (dst_code_r < 4'h6 ? 5'h2 : 5'h4) &&
		src_ext_len_r == (size_word_r ? 3'h2 : 3'h1))
		else $error("general compare cost wrong");
	a_cmp_quick_cost: assert property (
		done_r && form_r == bcd_pkg::FORM_COMPARE_QUICK
		|-> cycles_r == (dst_code_r < 4'h6 ? 5'h1 : 5'h3))
		else $error("quick compare cycles wrong");
	a_cmp_short_dest: assert property (
		done_r && form_r == bcd_pkg::FORM_COMPARE_IMM_SHORT |-> sdst >= 3'h3
		&& cycles_r == (sdst < 3'h5 ? 5'h1 : 5'h3) && length_r ==
		(sdst < 3'h5 ? 3'h2 : sdst == 3'h7 ? 3'h4 : 3'h3))
		else $error("short compare decode wrong");
	a_cmp_regmem_cost: assert property (
		done_r && form_r == bcd_pkg::FORM_COMPARE_REG_MEM |-> cycles_r ==
		5'h2 + 5'(src_code_r >= 4'h6) + 5'(dst_code_r >= 4'h6))
		else $error("register/memory compare cycles wrong");
	a_cmp_accum_cost: assert property (
		done_r && form_r == bcd_pkg::FORM_COMPARE_ACCUM
		|-> cycles_r == (ssrc == 2'h0 ? 5'h2 : 5'h3) && length_r ==
		(ssrc == 2'h3 ? 3'h3 : ssrc == 2'h0 ? 3'h1 : 3'h2))
		else $error("accumulator compare cost wrong");
endmodule

bind bcd_decoder bcd_decoder_properties i_bcd_decoder_properties (
	.clk, .rst, .vector_from_table, .byte_ready_r, .done_r, .form_r,
	.bit_op_r, .src_code_r, .dst_code_r, .size_word_r, .src_ext_len_r,
	.length_r, .cycles_r
);

/* testbench/bcd_fetch_model.sv */
// Instruction-fetch model that offers bytes to the decoder
`timescale 1ns/1ns
module bcd_fetch_model (
	input  logic       clk,
	input  logic       byte_ready_r,
	output logic       byte_valid,
	output logic [7:0] byte_data
);
	// Fixed break vector stays all ones when the table supplies the target
	logic [31:0] fixed_break_vector = 32'hffff_ffff;
	initial begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end
	// Called just after an edge; returns just after the taking edge
	task automatic put(input logic [7:0] b);
		byte_valid = 1'b1;
		byte_data = b;
		do @(posedge clk); while (byte_ready_r !== 1'b1);
		#1;
	endtask
	// Released data shows the inverse so stale bytes cannot pass
	task automatic idle();
		byte_valid = 1'b0;
		byte_data = ~byte_data;
		@(posedge clk);
		#1;
	endtask
endmodule

/* testbench/bcd_decoder_bench.sv */
// Self-checking bench for the bit and compare instruction decoder
`timescale 1ns/1ns
module bcd_decoder_bench;
	typedef struct {
		logic [47:0]        b;
		logic               t;
		bcd_pkg::bcd_form_e f;
		logic [2:0]         len;
		logic [4:0]         cyc;
	} bcd_row_s;
	typedef struct {
		logic [3:0]          sub;
		bcd_pkg::bcd_bitop_e op;
		logic                grp_b;
	} bcd_bop_s;
	logic clk, rst, vector_from_table, byte_valid;
	logic byte_ready_r, done_r, illegal_r, size_word_r;
	logic [7:0] byte_data;
	bcd_pkg::bcd_form_e form_r;
	bcd_pkg::bcd_bitop_e bit_op_r;
	bcd_pkg::bcd_class_e src_class_r, dst_class_r;
	logic [3:0] src_code_r, dst_code_r;
	logic [2:0] bit_num_r, src_ext_len_r, length_r;
	logic signed [3:0] quick_immediate_r;
	logic [31:0] ext_data_r;
	logic [4:0] cycles_r;
	int failures = 0;
	int n_compared = 0;
	bcd_row_s rows [18] = '{
		'{48'h00, 1'h0, bcd_pkg::FORM_SOFTWARE_BREAK, 3'h1, 5'h1b},
		'{48'h00, 1'h1, bcd_pkg::FORM_SOFTWARE_BREAK, 3'h1, 5'h1d},
		'{48'h124d, 1'h0, bcd_pkg::FORM_BIT_SET_SHORT, 3'h2, 5'h3},
		'{48'hf4d0, 1'h0, bcd_pkg::FORM_COMPARE_QUICK, 3'h2, 5'h1},
		'{48'h3412_7fd1, 1'h0, bcd_pkg::FORM_COMPARE_QUICK, 3'h4, 5'h3},
		'{48'h86d0, 1'h0, bcd_pkg::FORM_COMPARE_QUICK, 3'h2, 5'h3},
		'{48'h11eb, 1'h0, bcd_pkg::FORM_COMPARE_IMM_SHORT, 3'h2, 5'h1},
		'{48'h11ec, 1'h0, bcd_pkg::FORM_COMPARE_IMM_SHORT, 3'h2, 5'h1},
		'{48'h2211ed, 1'h0, bcd_pkg::FORM_COMPARE_IMM_SHORT, 3'h3, 5'h3},
		'{48'h2211ee, 1'h0, bcd_pkg::FORM_COMPARE_IMM_SHORT, 3'h3, 5'h3},
		'{48'h332211ef, 1'h0, bcd_pkg::FORM_COMPARE_IMM_SHORT, 3'h4, 5'h3},
		'{48'h01c0, 1'h0, bcd_pkg::FORM_COMPARE_REG_MEM, 3'h2, 5'h2},
		'{48'h60c1, 1'h0, bcd_pkg::FORM_COMPARE_REG_MEM, 3'h2, 5'h3},
		'{48'hbbaa88c0, 1'h0, bcd_pkg::FORM_COMPARE_REG_MEM, 3'h4, 5'h4},
		'{48'h38, 1'h0, bcd_pkg::FORM_COMPARE_ACCUM, 3'h1, 5'h2},
		'{48'h113d, 1'h0, bcd_pkg::FORM_COMPARE_ACCUM, 3'h2, 5'h3},
		'{48'h113a, 1'h0, bcd_pkg::FORM_COMPARE_ACCUM, 3'h2, 5'h3},
		'{48'h22113f, 1'h0, bcd_pkg::FORM_COMPARE_ACCUM, 3'h3, 5'h3}
	};
	bcd_bop_s bops [9] = '{
		'{bcd_pkg::SUB_BIT_INVERT, bcd_pkg::BOP_BIT_INVERT, 1'h0},
		'{bcd_pkg::SUB_BIT_SET, bcd_pkg::BOP_BIT_SET, 1'h0},
		'{bcd_pkg::SUB_BIT_TEST, bcd_pkg::BOP_BIT_TEST, 1'h0},
		'{bcd_pkg::SUB_BIT_INV_TEST, bcd_pkg::BOP_BIT_INVERTED_TEST, 1'h1},
		'{bcd_pkg::SUB_BIT_INV_XOR, bcd_pkg::BOP_BIT_INVERTED_XOR, 1'h1},
		'{bcd_pkg::SUB_BIT_OR, bcd_pkg::BOP_BIT_OR_CARRY, 1'h1},
		'{bcd_pkg::SUB_BIT_TST_CLR, bcd_pkg::BOP_BIT_TEST_AND_CLEAR, 1'h1},
		'{bcd_pkg::SUB_BIT_TST_SET, bcd_pkg::BOP_BIT_TEST_AND_SET, 1'h1},
		'{bcd_pkg::SUB_BIT_XOR, bcd_pkg::BOP_BIT_XOR_CARRY, 1'h1}
	};

	bcd_decoder i_bcd_decoder (
		.clk, .rst, .byte_valid, .byte_data, .vector_from_table,
		.byte_ready_r, .done_r, .illegal_r, .form_r, .bit_op_r,
		.src_class_r, .dst_class_r, .src_code_r, .dst_code_r, .bit_num_r,
		.size_word_r, .quick_immediate_r, .ext_data_r, .src_ext_len_r,
		.length_r, .cycles_r
	);
	bcd_fetch_model i_bcd_fetch_model (
		.clk, .byte_ready_r, .byte_valid, .byte_data
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [47:0] b, input logic [2:0] n);
		for (int k = 0; k < n; k++)
			i_bcd_fetch_model.put(b[k*8 +: 8]);
	endtask
	task stop_test;
		$display("compared %0d mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Whole run needs about 2100 ns
	initial begin
		#20000;
		failures++;
		stop_test();
	end

	initial begin
		bcd_row_s r;
		logic [2:0] n;
		logic [4:0] cyc;
		logic [2:0] cls;
		int k;
		rst = 1'h1;
		vector_from_table = 1'h0;
		repeat (6) @(posedge clk);
		#1;
		chk(byte_ready_r, 1'h0);
		chk(done_r, 1'h0);
		rst = 1'h0;
		@(posedge clk);
		#1;
		chk(byte_ready_r, 1'h1);
		$display("test reset done");
		// Odd rows follow an idle cycle, even rows come back to back
		foreach (rows[i]) begin
			r = rows[i];
			if (i % 2 == 1)
				i_bcd_fetch_model.idle();
			vector_from_table = r.t;
			send(r.b, r.len);
			chk(done_r, 1'h1);
			chk(form_r, r.f);
			chk(length_r, r.len);
			chk(cycles_r, r.cyc);
			if (r.f == bcd_pkg::FORM_BIT_SET_SHORT)
				chk(bit_num_r, r.b[2:0]);
			if (r.f == bcd_pkg::FORM_COMPARE_QUICK)
				chk($unsigned(quick_immediate_r), r.b[15:12]);
			if (r.f == bcd_pkg::FORM_COMPARE_IMM_SHORT)
				chk(dst_code_r, {1'h0, r.b[2:0]});
			if (r.f == bcd_pkg::FORM_COMPARE_ACCUM)
				chk({src_code_r, dst_code_r},
					{2'h0, r.b[1:0], 3'h0, r.b[2]});
		end
		vector_from_table = 1'h0;
		$display("test form rows done");
		foreach (bops[i])
			for (int c = 0; c < 16; c++) begin
				k = (c < 6) ? 0 : (c[3] && c[1]) ? 2 : 1;
				n = (c < 6 || c[3:2] == 2'h2) ? 3'h3 : c[3] ? 3'h4 : 3'h2;
				cyc = (k == 0 ? 5'h2 : k == 1 ? 5'h6 : 5'h3) + 5'(bops[i].grp_b);
				cls = (c < 4) ? 3'h0 : (c == 15) ? 3'h7 : 3'(c / 2 - 1);
				send({16'h0, 8'ha5, 8'h5a, bops[i].sub, c[3:0], 8'h7e}, n);
				chk(form_r, bcd_pkg::FORM_BIT_GENERAL);
				chk(bit_op_r, bops[i].op);
				chk(length_r, n);
				chk(cycles_r, cyc);
				chk(dst_class_r, cls);
			end
		$display("test bit operand codes done");
		send(48'h0056_3412_8877, 3'h5);
		chk(ext_data_r, 32'h0056_3412);
		chk(src_ext_len_r, 3'h2);
		chk(length_r, 3'h5);
		chk(size_word_r, 1'h1);
		send(48'h00cc_bbaa_8ec0, 3'h5);
		chk(ext_data_r, 32'h00cc_bbaa);
		chk(src_ext_len_r, 3'h1);
		chk(cycles_r, 5'h4);
		chk(src_class_r, 3'h3);
		$display("test extension order done");
		// Destination code 000 is not a short compare target
		i_bcd_fetch_model.put(8'he8);
		chk(illegal_r, 1'h1);
		chk(done_r, 1'h0);
		send(48'h00, 3'h1);
		chk(cycles_r, 5'h1b);
		// Short invert and short test forms
		send(48'h3356, 3'h2);
		chk(form_r, bcd_pkg::FORM_BIT_INVERT_SHORT);
		chk({bit_num_r, length_r}, {3'h6, 3'h2});
		send(48'h445b, 3'h2);
		chk(bit_op_r, bcd_pkg::BOP_BIT_TEST);
		$display("test illegal destination done");
		i_bcd_fetch_model.put(8'h77);
		i_bcd_fetch_model.idle();
		rst = 1'h1;
		#1;
		chk(byte_ready_r, 1'h0);
		chk(form_r, bcd_pkg::FORM_NONE);
		@(posedge clk);
		#1;
		rst = 1'h0;
		@(posedge clk);
		#1;
		send(48'h1180_76, 3'h3);
		chk(form_r, bcd_pkg::FORM_COMPARE_IMM_GEN);
		chk(cycles_r, 5'h2);
		chk(length_r, 3'h3);
		$display("test reset mid-instruction done");
		stop_test();
	end
endmodule
